// *** ipm_irq_status.sv ***
// interrupt pending, active, missed and aux fault status registers on apb
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

// usage notes
// - every apb transfer has one wait state: ready follows the first access edge
// - a write takes effect at the ready edge, the edge where the master finishes
// - a source request wins over a clear or a handler entry in the same cycle,
//   so no event is lost, at the price of a clear that seems not to work
// - sticky flags (missed, fault, event status) are cleared by writing ones;
//   a new event in the clearing cycle keeps its flag set
// - the whole 32-bit address is compared, so core-side and peripheral-side
//   registers share one decoder
// - only whole aligned words are decoded; there are no byte strobes
module ipm_irq_status
	import ipm_pkg::*;
	#(parameter int NSRC = IPM_NSRC) (
	// clock and reset
	input  wire logic              CLK,
	input  wire logic              RST_B,
	// apb slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [31:0]       PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic                   PREADY,
	output logic [31:0]            PRDATA,
	output logic                   PSLVERR,
	// interrupt sources, one-cycle request pulses, same clock
	input  wire logic [NSRC-1:0]   SRC_REQ,
	// core entry and exit of a handler, one-cycle pulses
	input  wire logic [NSRC-1:0]   ACK_ENTER,
	input  wire logic [NSRC-1:0]   ACK_EXIT,
	// bus fault report
	input  wire ipm_fault_t        FAULT,
	// pending state to the core and summary interrupt
	output logic [NSRC-1:0]        PENDING,
	output logic                   IRQ
);
	// ==========================================================
	// state
	logic [NSRC-1:0]     pend_q, pend_d;     // pending per source
	logic [NSRC-1:0]     act_q, act_d;       // active per source
	logic [NSRC-1:0]     miss_q, miss_d;     // missed flags
	logic [3:0]          afsr_q, afsr_d;     // aux fault flags
	logic [IPM_EV_N-1:0] evst_q, evst_d;     // sticky event status
	logic [IPM_EV_N-1:0] evmk_q, evmk_d;     // event mask
	logic [31:0]         rdat_q, rdat_d;     // read data register
	logic                rdy_q, rdy_d;       // access phase answer
	logic                err_q, err_d;       // slave error
	logic                irq_q, irq_d;       // interrupt output
	logic                acc;                // first access edge: the answer is built
	logic                wr, rd;             // write commit and read capture strobes
	logic [NSRC-1:0]     wmask;              // write data masked to sources
	logic [IPM_EV_N-1:0] ev;                 // events this cycle

	// address match, used by read and write paths
	function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
		return a == r;
	endfunction

	// ==========================================================
	// apb strobes
	// the answer is prepared at the first access edge and shown one cycle later,
	// so every transfer has exactly one wait state
	assign acc   = PSEL && PENABLE && !rdy_q;
	// a write lands at the edge where the master sees ready high, never earlier,
	// so the register changes in the cycle the master counts the transfer done
	assign wr    = PSEL && PENABLE && PWRITE && rdy_q;
	// read data is captured at the first access edge and held until ready
	assign rd    = acc && !PWRITE;
	// only the source bits of the write data reach the per-source registers
	assign wmask = PWDATA[NSRC-1:0];

	// ==========================================================
	// interrupt state next values
	always_comb begin
		pend_d = pend_q;
		act_d  = act_q;
		miss_d = miss_q;
		// a repeat request on a pending source inside IPM_MISS_MASK is recorded
		miss_d = miss_d | (SRC_REQ & pend_q & IPM_MISS_MASK);
		if (wr && hit(PADDR, IPM_MISS_ADDR)) begin
			// software clears missed flags by writing ones
			miss_d = miss_q & ~wmask;
			miss_d = miss_d | (SRC_REQ & pend_q);
		end
		miss_d = miss_d & IPM_MISS_MASK;
		// only ones in the write clear pending bits
		if (wr && hit(PADDR, IPM_PENDCLR_ADDR)) begin
			// unmapped_address_fault bits of the write word are never looked at
			pend_d = pend_d & ~wmask;
		end
		// software may raise pending too; this address reads back the same state
		if (wr && hit(PADDR, IPM_PENDSET_ADDR)) begin
			pend_d = pend_d | wmask;
		end
		// entering a handler moves pending to active
		pend_d = pend_d & ~ACK_ENTER;
		// a new request wins over a clear in the same cycle
		pend_d = pend_d | SRC_REQ;
		act_d  = (act_q | ACK_ENTER) & ~ACK_EXIT;
	end

	// ==========================================================
	// fault flags and event status next values
	always_comb begin
		afsr_d = afsr_q;
		evst_d = evst_q;
		evmk_d = evmk_q;
		// event bits: a fault report, a missed request, any request
		ev     = {FAULT.strobe, |(SRC_REQ & pend_q & IPM_MISS_MASK), |SRC_REQ};
		if (wr && hit(PADDR, IPM_AFSR_ADDR)) begin
			// fault flags are cleared by writing one
			afsr_d = afsr_q & ~PWDATA[3:0];
		end
		if (FAULT.strobe) begin
			// any flag already set means this fault overflows
			if (|afsr_q) begin
				afsr_d[IPM_AF_OVF] = 1'b1;
			end
			afsr_d[IPM_AF_WIDTH] = afsr_d[IPM_AF_WIDTH] | FAULT.width;
			afsr_d[IPM_AF_PRIV]  = afsr_d[IPM_AF_PRIV] | FAULT.priv;
			afsr_d[IPM_AF_UNMAP] = afsr_d[IPM_AF_UNMAP] | FAULT.unmap;
		end
		if (wr && hit(PADDR, IPM_IRQSTAT_ADDR)) begin
			evst_d = evst_q & ~PWDATA[IPM_EV_N-1:0];
		end
		// set wins over write-one-to-clear
		evst_d = evst_d | ev;
		if (wr && hit(PADDR, IPM_IRQMASK_ADDR)) begin
			evmk_d = PWDATA[IPM_EV_N-1:0];
		end
	end

	// ==========================================================
	// apb answer next values
	always_comb begin
		rdy_d  = acc; // one wait state, then ready for a single cycle
		err_d  = 1'b0;
		rdat_d = IPM_RST_VAL;
		irq_d  = |(evst_d & evmk_d);
		// the answer is built once per transfer, at the first access edge;
		// a write gets the same decode so that an unmapped write errors too
		if (acc) begin
			if (hit(PADDR, IPM_PENDCLR_ADDR) || hit(PADDR, IPM_PENDSET_ADDR)) begin
				rdat_d[NSRC-1:0] = pend_q;
			end else if (hit(PADDR, IPM_ACTIVE_ADDR)) begin
				rdat_d[NSRC-1:0] = act_q;
			end else if (hit(PADDR, IPM_MISS_ADDR)) begin
				rdat_d[NSRC-1:0] = miss_q;
			end else if (hit(PADDR, IPM_AFSR_ADDR)) begin
				rdat_d[3:0] = afsr_q;
			end else if (hit(PADDR, IPM_IRQSTAT_ADDR)) begin
				rdat_d[IPM_EV_N-1:0] = evst_q;
			end else if (hit(PADDR, IPM_IRQMASK_ADDR)) begin
				rdat_d[IPM_EV_N-1:0] = evmk_q;
			end else begin
				// unmapped address: error answer, reads zero
				err_d = 1'b1;
			end
			// a write answers with zero data
			if (!rd) begin
				rdat_d = IPM_RST_VAL;
			end
		end
	end

	// ==========================================================
	// registers, synchronous active-low reset to zero
	// interrupt state: reset leaves no source pending, active or missed
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			// reset values
			pend_q <= '0;
			act_q  <= '0;
			miss_q <= '0;
		end else begin
			// take the next values
			pend_q <= pend_d;
			act_q  <= act_d;
			miss_q <= miss_d;
		end
	end

	// fault flags, event status and event mask
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			// reset values
			afsr_q <= '0;
			evst_q <= '0;
			evmk_q <= '0;
		end else begin
			// take the next values
			afsr_q <= afsr_d;
			evst_q <= evst_d;
			evmk_q <= evmk_d;
		end
	end

	// apb answer and the interrupt output
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			// reset values: no answer pending, interrupt low
			rdat_q <= IPM_RST_VAL;
			rdy_q  <= 1'b0;
			err_q  <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			// take the next values
			rdat_q <= rdat_d;
			rdy_q  <= rdy_d;
			err_q  <= err_d;
			irq_q  <= irq_d;
		end
	end

	// outputs straight from flip-flops
	assign PREADY  = rdy_q;
	assign PRDATA  = rdat_q;
	assign PSLVERR = err_q;
	assign PENDING = pend_q;
	assign IRQ     = irq_q;

	// ==========================================================
	// assertions
	AST_CLR_ONE: assert property (@(posedge CLK) disable iff (!RST_B)
		(wr && hit(PADDR, IPM_PENDCLR_ADDR) && PWDATA[0] && !SRC_REQ[0])
		|=> !pend_q[0]) else $error("pending bit not cleared by one");
	AST_CLR_ZERO: assert property (@(posedge CLK) disable iff (!RST_B)
		(wr && hit(PADDR, IPM_PENDCLR_ADDR) && !PWDATA[5] && pend_q[5] && !ACK_ENTER[5])
		|=> pend_q[5]) else $error("pending bit lost on zero write");
	AST_REQ_SETS: assert property (@(posedge CLK) disable iff (!RST_B)
		SRC_REQ[16] |=> pend_q[16]) else $error("request did not pend");
	AST_ACTIVE: assert property (@(posedge CLK) disable iff (!RST_B)
		(ACK_ENTER[9] && !ACK_EXIT[9]) |=> act_q[9]) else $error("active bit not set");
	AST_MISS_RSV: assert property (@(posedge CLK) disable iff (!RST_B)
		(miss_q & ~IPM_MISS_MASK) == '0) else $error("unmapped_address_fault missed bit set");
	AST_MISS_SET: assert property (@(posedge CLK) disable iff (!RST_B)
		(SRC_REQ[4] && pend_q[4]) ##1 !(wr && hit(PADDR, IPM_MISS_ADDR) && PWDATA[4])
		|-> miss_q[4] ##1 miss_q[4]) else $error("missed flag lost");
	AST_OVF: assert property (@(posedge CLK) disable iff (!RST_B)
		(FAULT.strobe && |afsr_q) |=> afsr_q[IPM_AF_OVF]) else $error("no overflow flag");
	AST_WIDTH: assert property (@(posedge CLK) disable iff (!RST_B)
		(FAULT.strobe && FAULT.width) |=> afsr_q[IPM_AF_WIDTH])
		else $error("width fault not flagged");
	AST_PRIV: assert property (@(posedge CLK) disable iff (!RST_B)
		(FAULT.strobe && FAULT.priv) |=> afsr_q[IPM_AF_PRIV])
		else $error("privilege fault not flagged");
	AST_READ: assert property (@(posedge CLK) disable iff (!RST_B)
		(rd && hit(PADDR, IPM_PENDCLR_ADDR)) |=> PREADY && PRDATA[31:NSRC] == '0)
		else $error("bad pending read");
	// an unmapped-address report sets its flag
	AST_UNMAP: assert property (@(posedge CLK) disable iff (!RST_B)
		(FAULT.strobe && FAULT.unmap) |=> afsr_q[IPM_AF_UNMAP])
		else $error("unmapped fault not flagged");
	// a write of one clears a fault flag unless the same flag is reported again
	AST_FAULT_CLR: assert property (@(posedge CLK) disable iff (!RST_B)
		(wr && hit(PADDR, IPM_AFSR_ADDR) && PWDATA[IPM_AF_WIDTH]
		&& !(FAULT.strobe && FAULT.width)) |=> !afsr_q[IPM_AF_WIDTH])
		else $error("width fault flag not cleared");
	// the fault register reads zero above its four flags
	AST_AFSR_RSV: assert property (@(posedge CLK) disable iff (!RST_B)
		(rd && hit(PADDR, IPM_AFSR_ADDR)) |=> PRDATA[31:4] == '0)
		else $error("unmapped_address_fault fault bits not zero");

	// ==========================================================
	// apb answer checks
	// every access phase is answered after exactly one wait state
	AST_READY_WAIT: assert property (@(posedge CLK) disable iff (!RST_B)
		acc |=> PREADY) else $error("ready not after one wait state");
	// ready stands for a single cycle only
	AST_READY_ONE: assert property (@(posedge CLK) disable iff (!RST_B)
		PREADY |=> !PREADY) else $error("ready held too long");
	// an error answer only comes together with ready
	AST_ERR_READY: assert property (@(posedge CLK) disable iff (!RST_B)
		PSLVERR |-> PREADY) else $error("error without ready");
	// read data is zero whenever no answer stands
	AST_RDATA_IDLE: assert property (@(posedge CLK) disable iff (!RST_B)
		!PREADY |-> PRDATA == '0) else $error("read data outside answer");
	// the pending clear address reads the pending state of the access edge
	AST_PEND_READ: assert property (@(posedge CLK) disable iff (!RST_B)
		(rd && hit(PADDR, IPM_PENDCLR_ADDR)) |=> PRDATA[NSRC-1:0] == $past(pend_q))
		else $error("pending read data wrong");
	// the pending set address reads the same pending state
	AST_PEND_SETREAD: assert property (@(posedge CLK) disable iff (!RST_B)
		(rd && hit(PADDR, IPM_PENDSET_ADDR)) |=> PRDATA[NSRC-1:0] == $past(pend_q))
		else $error("pending set read data wrong");
	// the active register reads the active state of the access edge
	AST_ACT_READ: assert property (@(posedge CLK) disable iff (!RST_B)
		(rd && hit(PADDR, IPM_ACTIVE_ADDR)) |=> PRDATA[NSRC-1:0] == $past(act_q))
		else $error("active read data wrong");
	// the missed register reads the missed flags of the access edge
	AST_MISS_READ: assert property (@(posedge CLK) disable iff (!RST_B)
		(rd && hit(PADDR, IPM_MISS_ADDR)) |=> PRDATA[NSRC-1:0] == $past(miss_q))
		else $error("missed read data wrong");

	// ==========================================================
	// handler and missed flag checks
	// leaving a handler clears its active bit
	AST_ACT_EXIT: assert property (@(posedge CLK) disable iff (!RST_B)
		ACK_EXIT[16] |=> !act_q[16]) else $error("active bit not cleared");
	// the radio receive source shows active at its own bit
	AST_ACT_SET: assert property (@(posedge CLK) disable iff (!RST_B)
		(ACK_ENTER[10] && !ACK_EXIT[10]) |=> act_q[10]) else $error("receive not active");
	// entering a handler takes the source out of pending unless it requests again
	AST_ENTER_CLR: assert property (@(posedge CLK) disable iff (!RST_B)
		(ACK_ENTER[8] && !SRC_REQ[8]) |=> !pend_q[8]) else $error("pending kept on entry");
	// a write of one clears a missed flag unless a repeat request lands with it
	AST_MISS_CLR: assert property (@(posedge CLK) disable iff (!RST_B)
		(wr && hit(PADDR, IPM_MISS_ADDR) && PWDATA[7] && !(SRC_REQ[7] && pend_q[7]))
		|=> !miss_q[7]) else $error("missed flag not cleared");

	// ==========================================================
	// cover points of the main scenarios
	COV_ACTIVE: cover property (@(posedge CLK) |ACK_ENTER);
	COV_MISS: cover property (@(posedge CLK) SRC_REQ[12] && pend_q[12]);
	COV_CLR: cover property (@(posedge CLK) wr && hit(PADDR, IPM_PENDCLR_ADDR));
	COV_OVF: cover property (@(posedge CLK) FAULT.strobe && |afsr_q);
	COV_IRQ: cover property (@(posedge CLK) $rose(IRQ));
endmodule

// *** ipm_pkg.sv ***
// package: register map, field layout and carrier types of the interrupt status block
package ipm_pkg;
	// ==========================================================
	// register byte addresses (full map, all 32 bits decoded)
	localparam logic [31:0] IPM_MISS_ADDR    = 32'h4000a820;
	localparam logic [31:0] IPM_PENDCLR_ADDR = 32'he000e280;
	localparam logic [31:0] IPM_ACTIVE_ADDR  = 32'he000e300;
	localparam logic [31:0] IPM_AFSR_ADDR    = 32'he000ed3c;
	localparam logic [31:0] IPM_PENDSET_ADDR = 32'he000e200;
	localparam logic [31:0] IPM_IRQSTAT_ADDR = 32'h4000a830;
	localparam logic [31:0] IPM_IRQMASK_ADDR = 32'h4000a834;
	// ==========================================================
	// widths and field layout
	localparam int          IPM_NSRC      = 17;
	localparam logic [16:0] IPM_MISS_MASK = 17'h0fffc;
	localparam int          IPM_AF_WIDTH  = 3;
	localparam int          IPM_AF_PRIV   = 2;
	localparam int          IPM_AF_UNMAP  = 1;
	localparam int          IPM_AF_OVF    = 0;
	localparam logic [31:0] IPM_RST_VAL   = 32'h00000000;
	// event status bits: 0 any request, 1 any missed, 2 any fault
	localparam int          IPM_EV_N      = 3;
	// ==========================================================
	// bus fault report from the bus matrix, one cycle
	typedef struct packed {
		logic strobe;
		logic width;
		logic priv;
		logic unmap;
	} ipm_fault_t;
endpackage

// *** ipm_core_model.sv ***
// partner model: interrupt sources, processor core handshakes and bus fault reports
`timescale 1ns/1ps
module ipm_core_model
	import ipm_pkg::*; (
	// pulses towards the status block
	output logic [16:0] SRC_REQ,
	output logic [16:0] ACK_ENTER,
	output logic [16:0] ACK_EXIT,
	output ipm_fault_t  FAULT,
	// clock
	input  wire logic   CLK
);
	// ==========================================================
	// idle state: all lines low between pulses
	initial begin
		SRC_REQ = '0;
		ACK_ENTER = '0;
		ACK_EXIT = '0;
		FAULT = '0;
	end
	// ==========================================================
	// one-cycle pulse, raised and dropped just after rising edges
	task automatic pulse(input int k, input logic [16:0] v);
		@(posedge CLK);
		case (k)
			0: SRC_REQ <= v;
			1: ACK_ENTER <= v;
			2: ACK_EXIT <= v;
			default: FAULT <= ipm_fault_t'(v[3:0]);
		endcase
		@(posedge CLK);
		SRC_REQ <= '0;
		ACK_ENTER <= '0;
		ACK_EXIT <= '0;
		FAULT <= '0;
	endtask
endmodule

// *** testbench.sv ***
// self-checking testbench of the interrupt status block
`timescale 1ns/1ps
module testbench
	import ipm_pkg::*;
	;
	// ==========================================================
	// stimulus and observed signals
	logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic        pready, pslverr, irq, se;
	logic [16:0] src_req, ack_enter, ack_exit, pending, r, c;
	ipm_fault_t  fault;
	int          err_count = 0, compares = 0;
	always #10 clk = ~clk;
	ipm_irq_status u_ipm_irq_status (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .SRC_REQ(src_req),
		.ACK_ENTER(ack_enter), .ACK_EXIT(ack_exit), .FAULT(fault),
		.PENDING(pending), .IRQ(irq));
	ipm_core_model u_ipm_core_model (.SRC_REQ(src_req), .ACK_ENTER(ack_enter),
		.ACK_EXIT(ack_exit), .FAULT(fault), .CLK(clk));
	// ==========================================================
	// comparison, verdict and bus tasks
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	// expected register words from the rules: pending after a clear, missed flags
	function automatic logic [31:0] exp_pend(input logic [16:0] set, input logic [16:0] clr);
		return {15'h0, set & ~clr};
	endfunction
	function automatic logic [31:0] exp_miss(input logic [16:0] rep);
		return {15'h0, rep & IPM_MISS_MASK};
	endfunction
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] exp);
		apb(0, a, '0);
		chk(n, rd, exp);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		r = 17'($urandom(49));
		repeat (20) @(posedge clk);
		rst_b <= 1;
		rdc("pendclr", IPM_PENDCLR_ADDR, '0);
		rdc("active", IPM_ACTIVE_ADDR, '0);
		rdc("missed", IPM_MISS_ADDR, '0);
		rdc("afsr", IPM_AFSR_ADDR, '0);
		$display("test reset values done");
		// the first round sets every source, unmapped_address_fault write bits always high
		for (int i = 0; i < 5; i++) begin
			r = (i == 0) ? '1 : 17'($urandom);
			c = 17'($urandom);
			apb(1, IPM_MISS_ADDR, '1);
			u_ipm_core_model.pulse(0, r);
			u_ipm_core_model.pulse(0, r);
			rdc("pendclr", IPM_PENDCLR_ADDR, exp_pend(r, '0));
			rdc("missed", IPM_MISS_ADDR, exp_miss(r));
			apb(1, IPM_PENDCLR_ADDR, {15'h7fff, c});
			// the clear lands at the ready edge; look one edge later
			@(posedge clk);
			chk("pending", {15'h0, pending}, exp_pend(r, c));
			rdc("pendclr", IPM_PENDCLR_ADDR, exp_pend(r, c));
			apb(1, IPM_PENDCLR_ADDR, '1);
		end
		// software may raise pending too; both addresses read the same state
		apb(1, IPM_PENDSET_ADDR, {15'h7fff, c});
		rdc("pendset", IPM_PENDSET_ADDR, exp_pend(c, '0));
		rdc("pendclr", IPM_PENDCLR_ADDR, exp_pend(c, '0));
		apb(1, IPM_PENDCLR_ADDR, '1);
		@(posedge clk);
		chk("pending", {15'h0, pending}, '0);
		$display("test pending and missed done");
		u_ipm_core_model.pulse(0, 17'h10700);
		u_ipm_core_model.pulse(1, 17'h10700);
		rdc("active", IPM_ACTIVE_ADDR, 32'h00010700);
		u_ipm_core_model.pulse(2, 17'h10700);
		rdc("active", IPM_ACTIVE_ADDR, '0);
		$display("test active done");
		// fault pulse bits: strobe, width, privilege, unmapped
		u_ipm_core_model.pulse(3, 17'hc);
		rdc("afsr", IPM_AFSR_ADDR, 32'h8);
		u_ipm_core_model.pulse(3, 17'ha);
		rdc("afsr", IPM_AFSR_ADDR, 32'hd);
		apb(1, IPM_AFSR_ADDR, 32'hf);
		u_ipm_core_model.pulse(3, 17'h9);
		rdc("afsr", IPM_AFSR_ADDR, 32'h2);
		rdc("unmapped", 32'h4000a900, '0);
		chk("slverr", {31'h0, se}, 32'h1);
		$display("test faults done");
		chk("irq", {31'h0, irq}, '0);
		apb(1, IPM_IRQMASK_ADDR, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1, IPM_IRQSTAT_ADDR, 32'h7);
		repeat (2) @(posedge clk);
		chk("irq", {31'h0, irq}, '0);
		$display("test interrupt done");
		test_done;
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#400us;
		err_count++;
		test_done;
	end
endmodule
